// File: jfda_pkg.sv
// Constants and carrier types for the JTAG flash data access block.
// Assumes a single core clock domain plus the JTAG test clock domain.
package jfda_pkg;

   // Register widths
   localparam int JFDA_DATA_W = 10;
   localparam int JFDA_ADDR_W = 17;
   localparam int JFDA_CTRL_W = 8;
   localparam int JFDA_SHIFT_W = 17;

   // Data register field positions
   localparam int JFDA_DAT_MSB = 9;
   localparam int JFDA_DAT_LSB = 2;
   localparam int JFDA_FAIL_BIT = 1;
   localparam int JFDA_BUSY_BIT = 0;

   // Control register field positions
   localparam int JFDA_SCR_BIT = 7;
   localparam int JFDA_WRMD_MSB = 6;
   localparam int JFDA_WRMD_LSB = 4;
   localparam int JFDA_RDMD_MSB = 3;
   localparam int JFDA_RDMD_LSB = 0;

   // Reset values
   localparam logic [9:0] JFDA_DATA_RST = 10'h000;
   localparam logic [7:0] JFDA_CTRL_RST = 8'h00;
   localparam logic [16:0] JFDA_ADDR_RST = 17'h00000;

   // Write mode codes
   localparam logic [2:0] JFDA_WR_HOLD = 3'h0;
   localparam logic [2:0] JFDA_WR_PROG = 3'h1;
   localparam logic [2:0] JFDA_WR_ERASE = 3'h2;

   // Read mode codes
   localparam logic [3:0] JFDA_RD_HOLD = 4'h0;
   localparam logic [3:0] JFDA_RD_BLOCK = 4'h1;
   localparam logic [3:0] JFDA_RD_SINGLE = 4'h2;

   // Erase key and address step
   localparam logic [7:0] JFDA_ERASE_KEY = 8'ha5;
   localparam logic [16:0] JFDA_ADDR_STEP = 17'h00001;

   // Synchroniser depth
   localparam int JFDA_SYNC_STAGES = 2;

   // Data register selected at the scan chain
   typedef enum logic [1:0] {
      JFDA_SEL_NONE,
      JFDA_SEL_CTRL,
      JFDA_SEL_ADDR,
      JFDA_SEL_DATA
   } jfda_sel_t;

   // Flash operation kinds
   typedef enum logic [1:0] {
      JFDA_OP_READ,
      JFDA_OP_PROG,
      JFDA_OP_ERASE
   } jfda_op_t;

   // Command handed to the flash array
   typedef struct packed {
      jfda_op_t op;
      logic scratch;
      logic [16:0] addr;
      logic [7:0] wdata;
   } jfda_cmd_t;

   // Answer from the flash array
   typedef struct packed {
      logic [7:0] rdata;
      logic fail;
   } jfda_resp_t;

endpackage

// File: jfda_sync.sv
// Two flip-flop synchroniser for a group of levels or toggles.
// Assumes the inputs are glitch-free flop outputs from another domain.
`timescale 1ns/1ns
module jfda_sync import jfda_pkg::*; #(
   parameter int WIDTH = 1
) (
   // Destination clock
   input wire logic clk,
   // Asynchronous levels in, synchronised levels out
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk) begin
      stage1 <= din;
      dout <= stage1;
   end

endmodule // jfda_sync

// File: jfda_top.sv
// JTAG flash data path with its control and address registers, plus a watchdog enable cleared in debug halt or step and a periph_run output held high.
// Assumes a TAP controller drives select, capture, shift and update on the test clock.
`timescale 1ns/1ns
module jfda_top import jfda_pkg::*; (
   // Core clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // JTAG link, clocked by the test clock
   input wire logic tck,
   input wire logic tdi,
   input wire jfda_sel_t dr_sel,
   input wire logic dr_capture,
   input wire logic dr_shift,
   input wire logic dr_update,
   output logic tdo,
   // Flash array port, core clock
   output logic flash_req,
   output jfda_cmd_t flash_cmd,
   input wire logic flash_ack,
   input wire jfda_resp_t flash_resp,
   // Debug state from the processor, core clock
   input wire logic cpu_halted,
   input wire logic cpu_stepping,
   output logic watchdog_timer_en,
   output logic periph_run
);

   // Cross-domain signals
   logic tck_rst;
   logic req_tog;
   logic req_tog_sync;
   logic done_tog;
   logic done_tog_sync;
   jfda_cmd_t pend_cmd;
   jfda_resp_t result;

   // Test clock domain state
   logic [7:0] ctrl_reg;
   logic [16:0] jtag_flash_address;
   logic [7:0] data_byte;
   logic fail_flag;
   logic [16:0] shift_reg;
   logic done_seen;
   logic unseen;
   logic [7:0] next_ctrl_reg;
   logic [16:0] next_jtag_flash_address;
   logic [7:0] next_data_byte;
   logic next_fail_flag;
   logic [16:0] next_shift_reg;
   logic next_req_tog;
   logic next_done_seen;
   logic next_unseen;
   logic next_tdo;
   jfda_cmd_t next_pend_cmd;

   // Field views
   logic scratch_sector_sel;
   logic [2:0] write_mode_sel;
   logic [3:0] read_mode_sel;
   logic busy;
   logic [9:0] jtag_flash_data;
   logic [7:0] upd_byte;

   assign scratch_sector_sel = ctrl_reg[JFDA_SCR_BIT];
   assign write_mode_sel = ctrl_reg[JFDA_WRMD_MSB:JFDA_WRMD_LSB];
   assign read_mode_sel = ctrl_reg[JFDA_RDMD_MSB:JFDA_RDMD_LSB];
   assign busy = req_tog ^ done_seen;
   assign jtag_flash_data = {data_byte, fail_flag, busy};
   assign upd_byte = shift_reg[JFDA_DAT_MSB:JFDA_DAT_LSB];

   // Reset and handshake crossings
   jfda_sync #(.WIDTH(1)) u_rst_sync (
      .clk(tck),
      .din(sys_rst),
      .dout(tck_rst)
   );

   jfda_sync #(.WIDTH(1)) u_done_sync (
      .clk(tck),
      .din(done_tog),
      .dout(done_tog_sync)
   );

   jfda_sync #(.WIDTH(1)) u_req_sync (
      .clk(clock),
      .din(req_tog),
      .dout(req_tog_sync)
   );

   // Test clock domain: scan chain, registers and request issue
   always_comb begin
      next_ctrl_reg = ctrl_reg;
      next_jtag_flash_address = jtag_flash_address;
      next_data_byte = data_byte;
      next_fail_flag = fail_flag;
      next_shift_reg = shift_reg;
      next_req_tog = req_tog;
      next_done_seen = done_seen;
      next_unseen = unseen;
      next_pend_cmd = pend_cmd;
      // Completion of a flash operation
      if (done_tog_sync != done_seen) begin
         next_done_seen = done_tog_sync;
         next_fail_flag = result.fail;
         if (pend_cmd.op == JFDA_OP_READ) begin
            next_data_byte = result.rdata;
            next_unseen = 1'b1;
         end
         if (pend_cmd.op == JFDA_OP_PROG && !result.fail) begin
            next_jtag_flash_address = jtag_flash_address + JFDA_ADDR_STEP;
         end
      end
      // Scan strobes never lost to a completion
      if (dr_capture) begin
         unique case (dr_sel)
            JFDA_SEL_CTRL: next_shift_reg = {9'h000, ctrl_reg};
            JFDA_SEL_ADDR: next_shift_reg = jtag_flash_address;
            JFDA_SEL_DATA: begin
               next_shift_reg = {7'h00, jtag_flash_data};
               if (!busy) begin
                  next_unseen = 1'b0;
                  if (read_mode_sel == JFDA_RD_BLOCK ||
                      (read_mode_sel == JFDA_RD_SINGLE && !unseen)) begin
                     next_pend_cmd.op = JFDA_OP_READ;
                     next_pend_cmd.scratch = scratch_sector_sel;
                     next_pend_cmd.addr = jtag_flash_address;
                     next_req_tog = ~req_tog;
                  end
               end
            end
            default: next_shift_reg = shift_reg;
         endcase
      end else if (dr_shift) begin
         next_shift_reg = shift_reg >> 1;
         unique case (dr_sel)
            JFDA_SEL_CTRL: next_shift_reg[JFDA_CTRL_W-1] = tdi;
            JFDA_SEL_ADDR: next_shift_reg[JFDA_ADDR_W-1] = tdi;
            JFDA_SEL_DATA: next_shift_reg[JFDA_DATA_W-1] = tdi;
            default: next_shift_reg = shift_reg;
         endcase
      end else if (dr_update) begin
         unique case (dr_sel)
            JFDA_SEL_CTRL: next_ctrl_reg = shift_reg[JFDA_CTRL_W-1:0];
            JFDA_SEL_ADDR: begin
               if (!busy) begin
                  next_jtag_flash_address = shift_reg;
               end
            end
            JFDA_SEL_DATA: begin
               if (!busy) begin
                  next_data_byte = upd_byte;
                  next_pend_cmd.scratch = scratch_sector_sel;
                  next_pend_cmd.addr = jtag_flash_address;
                  next_pend_cmd.wdata = upd_byte;
                  if (write_mode_sel == JFDA_WR_PROG) begin
                     next_pend_cmd.op = JFDA_OP_PROG;
                     next_req_tog = ~req_tog;
                  end else if (write_mode_sel == JFDA_WR_ERASE &&
                               upd_byte == JFDA_ERASE_KEY) begin
                     next_pend_cmd.op = JFDA_OP_ERASE;
                     next_req_tog = ~req_tog;
                  end
               end
            end
            default: next_ctrl_reg = ctrl_reg;
         endcase
      end
      next_tdo = next_shift_reg[0];
   end

   always_ff @(posedge tck) begin
      if (tck_rst) begin
         ctrl_reg <= JFDA_CTRL_RST;
         jtag_flash_address <= JFDA_ADDR_RST;
         data_byte <= JFDA_DATA_RST[JFDA_DAT_MSB:JFDA_DAT_LSB];
         fail_flag <= JFDA_DATA_RST[JFDA_FAIL_BIT];
         shift_reg <= '0;
         req_tog <= 1'b0;
         done_seen <= 1'b0;
         unseen <= 1'b0;
         pend_cmd <= '0;
         tdo <= 1'b0;
      end else begin
         ctrl_reg <= next_ctrl_reg;
         jtag_flash_address <= next_jtag_flash_address;
         data_byte <= next_data_byte;
         fail_flag <= next_fail_flag;
         shift_reg <= next_shift_reg;
         req_tog <= next_req_tog;
         done_seen <= next_done_seen;
         unseen <= next_unseen;
         pend_cmd <= next_pend_cmd;
         tdo <= next_tdo;
      end
   end

   // Core clock domain: flash request engine
   typedef enum logic {
      JFDA_ST_IDLE,
      JFDA_ST_WAIT
   } jfda_state_t;

   jfda_state_t state;
   jfda_state_t next_state;
   logic req_seen;
   logic next_req_seen;
   logic next_flash_req;
   jfda_cmd_t next_flash_cmd;
   jfda_resp_t next_result;
   logic next_done_tog;
   logic next_watchdog_timer_en;

   always_comb begin
      next_state = state;
      next_req_seen = req_seen;
      next_flash_req = 1'b0;
      next_flash_cmd = flash_cmd;
      next_result = result;
      next_done_tog = done_tog;
      unique case (state)
         JFDA_ST_IDLE: begin
            if (req_tog_sync != req_seen) begin
               next_req_seen = req_tog_sync;
               next_flash_cmd = pend_cmd;
               next_flash_req = 1'b1;
               next_state = JFDA_ST_WAIT;
            end
         end
         JFDA_ST_WAIT: begin
            if (flash_ack) begin
               next_result = flash_resp;
               next_done_tog = ~done_tog;
               next_state = JFDA_ST_IDLE;
            end
         end
      endcase
      next_watchdog_timer_en = !(cpu_halted || cpu_stepping);
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state <= JFDA_ST_IDLE;
         req_seen <= 1'b0;
         flash_req <= 1'b0;
         flash_cmd <= '0;
         result <= '0;
         done_tog <= 1'b0;
         watchdog_timer_en <= 1'b1;
         periph_run <= 1'b1;
      end else begin
         state <= next_state;
         req_seen <= next_req_seen;
         flash_req <= next_flash_req;
         flash_cmd <= next_flash_cmd;
         result <= next_result;
         done_tog <= next_done_tog;
         watchdog_timer_en <= next_watchdog_timer_en;
         periph_run <= 1'b1;
      end
   end

endmodule // jfda_top

// File: jfda_properties.sv
// Checker on the flash port and debug outputs.
// Bound into jfda_top; core clock domain only.
`timescale 1ns/1ns
module jfda_properties import jfda_pkg::*; (
   // Core clock
   input wire logic clock,
   input wire logic sys_rst,
   // Flash port
   input wire logic flash_req,
   input wire jfda_cmd_t flash_cmd,
   input wire logic flash_ack,
   // Debug
   input wire logic cpu_halted,
   input wire logic cpu_stepping,
   input wire logic watchdog_timer_en,
   input wire logic periph_run
);
   logic pend;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Request open until answered
   always_ff @(posedge clock) pend <= !sys_rst && (flash_req || (pend && !flash_ack));
   a_wdt_halt: assert property ((cpu_halted || cpu_stepping) |=> !watchdog_timer_en)
      else $error("wdt on in debug");
   a_wdt_run: assert property (!(cpu_halted || cpu_stepping) |=> watchdog_timer_en)
      else $error("wdt off");
   a_periph_on: assert property (periph_run)
      else $error("periph stopped");
   a_req_pulse: assert property (flash_req |=> !flash_req)
      else $error("long request");
   a_one_open: assert property (pend |-> !flash_req)
      else $error("request while busy");
   a_cmd_hold: assert property (!flash_req |-> $stable(flash_cmd))
      else $error("command moved");
   a_erase_key: assert property (flash_req && flash_cmd.op == JFDA_OP_ERASE
      |-> flash_cmd.wdata == JFDA_ERASE_KEY) else $error("erase without key");
   a_reset_out: assert property (disable iff (1'b0) sys_rst |=> watchdog_timer_en && !flash_req)
      else $error("bad reset outputs");
   c_prog: cover property (flash_req && flash_cmd.op == JFDA_OP_PROG);
   c_read: cover property (flash_req && flash_cmd.op == JFDA_OP_READ);
   c_erase: cover property (flash_req && flash_cmd.op == JFDA_OP_ERASE);
endmodule // jfda_properties
bind jfda_top jfda_properties u_props (.clock, .sys_rst, .flash_req, .flash_cmd, .flash_ack,
   .cpu_halted, .cpu_stepping, .watchdog_timer_en, .periph_run);

// File: jfda_flash_model.sv
// Behavioural flash array on the flash port.
// Assumes one request at a time; addresses from 1f000 are locked.
`timescale 1ns/1ns
module jfda_flash_model import jfda_pkg::*; (
   // Core clock
   input wire logic clock,
   // Flash port
   input wire logic flash_req,
   input wire jfda_cmd_t flash_cmd,
   output logic flash_ack = 1'b0,
   output jfda_resp_t flash_resp = '0
);
   localparam logic [16:0] LOCKED = 17'h1f000;
   int lat = 3;
   int cnt = 0;
   int reqs = 0;
   jfda_cmd_t last = '0;
   logic [7:0] mem [256] = '{default: 8'h00};
   logic ok;
   always @(posedge clock) begin
      ok = last.addr < LOCKED;
      flash_ack <= 1'b0;
      flash_resp <= ~flash_resp;
      if (cnt == 1) begin
         flash_ack <= 1'b1;
         flash_resp.fail <= !ok;
         flash_resp.rdata <= mem[last.addr[7:0]];
         if (ok && last.op == JFDA_OP_PROG) mem[last.addr[7:0]] = last.wdata;
         if (ok && last.op == JFDA_OP_ERASE) mem = '{default: 8'hff};
      end
      if (cnt != 0) cnt <= cnt - 1;
      if (flash_req) begin
         reqs <= reqs + 1;
         last <= flash_cmd;
         cnt <= lat;
      end
   end
endmodule // jfda_flash_model

// File: testbench.sv
// Self-checking bench for jfda_top over its scan chain.
// Assumes free-running clocks; stimulus on falling edges.
`timescale 1ns/1ns
module testbench import jfda_pkg::*; ();
   logic clock = 1'b0, tck = 1'b0, sys_rst = 1'b1, tdi = 1'b0;
   logic dr_capture = 1'b0, dr_shift = 1'b0, dr_update = 1'b0;
   logic cpu_halted = 1'b0, cpu_stepping = 1'b0;
   jfda_sel_t dr_sel = JFDA_SEL_NONE;
   logic tdo, flash_req, flash_ack, watchdog_timer_en, periph_run;
   jfda_cmd_t flash_cmd;
   jfda_resp_t flash_resp;
   int failures = 0, check_count = 0, r;
   logic [16:0] o;
   always #50 clock = ~clock;
   always #24 tck = ~tck;
   jfda_top dut (.clock, .sys_rst, .tck, .tdi, .dr_sel, .dr_capture, .dr_shift, .dr_update,
      .tdo, .flash_req, .flash_cmd, .flash_ack, .flash_resp, .cpu_halted, .cpu_stepping,
      .watchdog_timer_en, .periph_run);
   jfda_flash_model fm (.clock, .flash_req, .flash_cmd, .flash_ack, .flash_resp);
   task chk(input logic [16:0] s, input logic [16:0] e);
      check_count++;
      if (s !== e) begin
         failures++;
         $display("BAD t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Capture, shift n bits LSB first, optional update
   task scan(input jfda_sel_t s, input int n, input logic [16:0] v, input logic u);
      @(negedge tck);
      o = '0;
      dr_sel = s;
      dr_capture = 1'b1;
      @(negedge tck);
      dr_capture = 1'b0;
      dr_shift = 1'b1;
      for (int i = 0; i < n; i++) begin
         tdi = v[i];
         o[i] = tdo;
         @(negedge tck);
      end
      dr_shift = 1'b0;
      dr_update = u;
      @(negedge tck);
      dr_update = 1'b0;
      dr_sel = JFDA_SEL_NONE;
   endtask
   task dat(input logic [7:0] b);
      scan(JFDA_SEL_DATA, 10, {7'h00, b, 2'b00}, 1'b1);
   endtask
   task ctl(input logic [7:0] c);
      scan(JFDA_SEL_CTRL, 8, {9'h000, c}, 1'b1);
   endtask
   task adr(input logic [16:0] a);
      scan(JFDA_SEL_ADDR, 17, a, 1'b1);
   endtask
   // Poll data register until not busy
   task idle;
      for (int k = 0; k < 200; k++) begin
         scan(JFDA_SEL_DATA, 10, 17'h00000, 1'b0);
         if (o[0] === 1'b0) break;
      end
   endtask
   initial begin
      repeat (5) @(posedge clock);
      @(negedge clock);
      sys_rst = 1'b0;
      repeat (4) @(negedge tck);
      scan(JFDA_SEL_DATA, 10, 17'h00000, 1'b0);
      chk(o, {7'h00, JFDA_DATA_RST});
      chk(watchdog_timer_en, 1'b1);
      ctl(8'h00);
      adr(17'h00010);
      dat(8'h3c);
      scan(JFDA_SEL_DATA, 10, 17'h00000, 1'b0);
      chk(o, 17'h000f0);
      chk(17'(fm.reqs), 17'h00000);
      $display("done store");
      ctl(8'h10);
      dat(8'h3c);
      idle;
      chk(o[1], 1'b0);
      chk(fm.last.addr, 17'h00010);
      dat(8'h77);
      idle;
      chk(fm.last.addr, 17'h00011);
      chk(fm.mem[8'h11], 8'h77);
      $display("done program");
      adr(17'h00010);
      ctl(8'h01);
      r = fm.reqs;
      scan(JFDA_SEL_DATA, 10, 17'h00000, 1'b0);
      ctl(8'h00);
      idle;
      chk(o[9:2], 8'h3c);
      chk(fm.last.op, JFDA_OP_READ);
      chk(17'(fm.reqs), 17'(r + 1));
      ctl(8'h02);
      r = fm.reqs;
      scan(JFDA_SEL_DATA, 10, 17'h00000, 1'b0);
      idle;
      chk(17'(fm.reqs), 17'(r + 1));
      chk(o[9:2], 8'h3c);
      scan(JFDA_SEL_DATA, 10, 17'h00000, 1'b0);
      ctl(8'h00);
      idle;
      chk(17'(fm.reqs), 17'(r + 2));
      $display("done read");
      ctl(8'h20);
      adr(17'h00040);
      r = fm.reqs;
      dat(8'h12);
      idle;
      chk(17'(fm.reqs), 17'(r));
      dat(8'ha5);
      idle;
      chk(fm.last.op, JFDA_OP_ERASE);
      chk(fm.mem[8'h41], 8'hff);
      ctl(8'h10);
      dat(8'h01);
      idle;
      chk(fm.last.addr, 17'h00040);
      $display("done erase");
      adr(17'h1f000);
      dat(8'h00);
      idle;
      chk(o[1], 1'b1);
      dat(8'h00);
      idle;
      chk(fm.last.addr, 17'h1f000);
      $display("done locked");
      fm.lat = 60;
      adr(17'h00020);
      r = fm.reqs;
      dat(8'h55);
      scan(JFDA_SEL_DATA, 10, 17'h00000, 1'b0);
      chk(o[0], 1'b1);
      dat(8'h66);
      idle;
      chk(17'(fm.reqs), 17'(r + 1));
      chk(fm.mem[8'h20], 8'h55);
      fm.lat = 3;
      ctl(8'h90);
      dat(8'h11);
      idle;
      chk(fm.last.scratch, 1'b1);
      $display("done busy");
      @(negedge clock);
      cpu_halted = 1'b1;
      repeat (2) @(negedge clock);
      chk(watchdog_timer_en, 1'b0);
      chk(periph_run, 1'b1);
      cpu_halted = 1'b0;
      cpu_stepping = 1'b1;
      repeat (2) @(negedge clock);
      chk(watchdog_timer_en, 1'b0);
      cpu_stepping = 1'b0;
      repeat (2) @(negedge clock);
      chk(watchdog_timer_en, 1'b1);
      $display("done debug");
      end_of_test;
   end
   initial begin
      #3000000;
      failures++;
      end_of_test;
   end
endmodule // testbench
